// ---- hw/flash_sr_pkg.sv ----
// package: command codes, status layout, identity bytes and timing for the status/id block
package flash_sr_pkg;
    // command codes
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_RDID = 8'h9f;
    localparam logic [7:0] CMD_RDSR = 8'h05;
    localparam logic [7:0] CMD_WRSR = 8'h01;
    localparam logic [7:0] CMD_BULK = 8'hc7;
    // status byte field positions
    localparam int BUSY_BIT = 0;
    localparam int WLATCH_BIT = 1;
    localparam int PSIZE_LO_BIT = 2;
    localparam int PSIZE_HI_BIT = 3;
    localparam int LOCK_BIT = 7;
    // reset values of the non-volatile bits (delivery state)
    localparam logic [1:0] PSIZE_RESET = 2'h0;
    localparam logic LOCK_RESET = 1'b0;
    // identity bytes: arbitrary neutral values, not any real part's codes
    localparam logic [7:0] ID_MAKER = 8'h5a;
    localparam logic [7:0] ID_TYPE = 8'h3c;
    localparam logic [7:0] ID_CAP = 8'h07;
    // unique block length byte and byte counts
    localparam logic [7:0] UNIQUE_LEN = 8'h10;
    localparam int FACTORY_BYTES = 16;
    localparam int ID_BYTES = 20;
    // status write cycle time
    localparam int CLK_MHZ = 100;
    localparam int TW_US = 5;
    localparam int TW_CYCLES = TW_US * CLK_MHZ;

    // serial front-end state
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_RDID = 3'b010,
        ST_RDSR = 3'b011,
        ST_WRSR = 3'b100,
        ST_IGNORE = 3'b101
    } ser_state_e;

    // status byte as carried inside the block
    typedef struct packed
    {
        logic lock;
        logic [2:0] zero;
        logic [1:0] psize;
        logic wlatch;
        logic busy;
    } status_s;
endpackage : flash_sr_pkg

// ---- hw/flash_status_id_protect.sv ----
// serial command interpreter for id read, status read/write and status protection
//
// Functional notes
// - id is maker, type, capacity, then unique block
// - unique block starts with length 10h
// - factory data read-only, zero by default
// - id command ignored while a cycle runs
// - id bits driven on falling clock edges
// - chip select high ends output, standby
// - status byte repeats, readable while busy
// - busy is 1 during any internal cycle
// - latch 0 refuses write, program, erase
// - protect bits non-volatile, status write only
// - protect bits change only outside lock mode
// - bulk erase only with protect bits zero
// - lock bit and low pin give lock mode
// - busy and latch are internal, read-only
// - status write needs latch set first
// - one data byte; b6..b4 read zero
// - select must rise after eighth data bit
// - select rise starts timed cycle; its end clears latch
// - lock bit 0 allows write regardless of pin
// - lock bit 1 needs pin high to write
// - lock mode entered in either order
// - pin high means no lock mode ever
// - command 06h sets the write latch
// - commands one byte, msb first, 9fh/05h/01h
module flash_status_id_protect #(
    parameter int TW_CNT = flash_sr_pkg::TW_CYCLES,
    parameter logic [8*flash_sr_pkg::FACTORY_BYTES-1:0] FACTORY_DATA = '0
)(
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // serial bus pins
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    input wire logic wprot_n,
    // internal sequencers
    input wire logic seq_busy,
    input wire logic seq_done,
    // protection view for the sequencers
    output logic [1:0] protect_size,
    output logic write_latch_flag,
    output logic hardware_lock_mode,
    output logic bulk_erase_ok,
    input wire logic all_sectors_locked
);
    localparam int CW = $clog2(TW_CNT + 1);

    ////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed
    {
        logic [1:0] s_sel;
        logic [1:0] s_clk;
        logic [1:0] s_din;
        logic [1:0] s_wp;
        logic clk_d;
        flash_sr_pkg::ser_state_e st;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic [4:0] bytecnt;
        logic wr_full;
        logic [7:0] wr_data;
        logic [7:0] txbyte;
        logic dout;
        logic douten;
        logic [1:0] psize;
        logic lock;
        logic wlatch;
        logic wbusy;
        logic [CW-1:0] tw_cnt;
        logic bulk_ok;
        logic hlock;
    } core_s;

    core_s q_reg;
    core_s q_next;

    // byte of the id stream at a given position
    function automatic logic [7:0] id_byte(input logic [4:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (idx == 5'h00) b = flash_sr_pkg::ID_MAKER;
        else if (idx == 5'h01) b = flash_sr_pkg::ID_TYPE;
        else if (idx == 5'h02) b = flash_sr_pkg::ID_CAP;
        else if (idx == 5'h03) b = flash_sr_pkg::UNIQUE_LEN;
        else if (idx < 5'(flash_sr_pkg::ID_BYTES))
            b = FACTORY_DATA[8*(5'(flash_sr_pkg::FACTORY_BYTES) - 5'(idx - 5'h04)) - 1 -: 8];
        return b;
    endfunction

    // assembled status byte
    function automatic logic [7:0] stat_byte(input core_s c, input logic busy_in);
        flash_sr_pkg::status_s s;
        s.lock = c.lock;
        s.zero = 3'h0;
        s.psize = c.psize;
        s.wlatch = c.wlatch;
        s.busy = c.wbusy | busy_in;
        return s;
    endfunction

    // synchronised views; the first stages are read only by the second
    logic sel_act;
    logic clk_rise;
    logic clk_fall;
    logic hw_lock;
    logic any_busy;
    assign sel_act = ~q_reg.s_sel[1];
    assign clk_rise = q_reg.s_clk[1] & ~q_reg.clk_d;
    assign clk_fall = ~q_reg.s_clk[1] & q_reg.clk_d;
    assign hw_lock = q_reg.lock & ~q_reg.s_wp[1];
    assign any_busy = q_reg.wbusy | seq_busy;

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        logic [7:0] sh;
        logic [7:0] nb;
        sh = 8'h00;
        nb = 8'h00;
        q_next = q_reg;
        // two-flop synchronisers for every pin
        q_next.s_sel = {q_reg.s_sel[0], sel_n};
        q_next.s_clk = {q_reg.s_clk[0], sclk};
        q_next.s_din = {q_reg.s_din[0], serial_in};
        q_next.s_wp = {q_reg.s_wp[0], wprot_n};
        q_next.clk_d = q_reg.s_clk[1];
        // bulk erase gate for the sequencer
        q_next.bulk_ok = (q_reg.psize == 2'h0) & ~all_sectors_locked;
        q_next.hlock = hw_lock;
        // sequencer completion clears the latch; latch is never set by others
        if (seq_done)
            q_next.wlatch = 1'b0;
        // timed status write cycle
        if (q_reg.wbusy)
        begin
            if (q_reg.tw_cnt == CW'(1))
            begin
                q_next.wbusy = 1'b0;
                q_next.wlatch = 1'b0;
            end
            q_next.tw_cnt = q_reg.tw_cnt - CW'(1);
        end
        if (!sel_act)
        begin
            // deselect: standby; a status write fires only on an exact byte
            if (q_reg.st == flash_sr_pkg::ST_WRSR && q_reg.wr_full && q_reg.bitcnt == 3'h0
                && q_reg.wlatch && !hw_lock && !any_busy)
            begin
                q_next.lock = q_reg.wr_data[flash_sr_pkg::LOCK_BIT];
                q_next.psize = q_reg.wr_data[flash_sr_pkg::PSIZE_HI_BIT:
                                             flash_sr_pkg::PSIZE_LO_BIT];
                q_next.wbusy = 1'b1;
                q_next.tw_cnt = CW'(TW_CNT);
            end
            // write enable / disable act on clean byte boundary
            if (q_reg.st == flash_sr_pkg::ST_IGNORE && q_reg.bitcnt == 3'h0
                && q_reg.bytecnt == 5'h01 && !any_busy)
            begin
                if (q_reg.shreg == flash_sr_pkg::CMD_WREN)
                    q_next.wlatch = 1'b1;
                else if (q_reg.shreg == flash_sr_pkg::CMD_WRDI)
                    q_next.wlatch = 1'b0;
            end
            q_next.st = flash_sr_pkg::ST_IDLE;
            q_next.bitcnt = 3'h0;
            q_next.bytecnt = 5'h00;
            q_next.wr_full = 1'b0;
            q_next.douten = 1'b0;
            q_next.dout = 1'b0;
        end
        else
        begin
            if (q_reg.st == flash_sr_pkg::ST_IDLE)
                q_next.st = flash_sr_pkg::ST_CMD;
            // input bits on rising edges, msb first
            if (clk_rise)
            begin
                sh = {q_reg.shreg[6:0], q_reg.s_din[1]};
                q_next.shreg = sh;
                q_next.bitcnt = q_reg.bitcnt + 3'h1;
                if (q_reg.bitcnt == 3'h7)
                begin
                    q_next.bytecnt = q_reg.bytecnt + 5'h01;
                    unique case (q_reg.st)
                        flash_sr_pkg::ST_IDLE,
                        flash_sr_pkg::ST_CMD:
                        begin
                            q_next.bytecnt = 5'h01;
                            if (sh == flash_sr_pkg::CMD_RDID && !any_busy)
                            begin
                                q_next.st = flash_sr_pkg::ST_RDID;
                                q_next.txbyte = id_byte(5'h00);
                                q_next.bytecnt = 5'h00;
                            end
                            else if (sh == flash_sr_pkg::CMD_RDSR)
                            begin
                                q_next.st = flash_sr_pkg::ST_RDSR;
                                q_next.txbyte = stat_byte(q_reg, seq_busy);
                            end
                            else if (sh == flash_sr_pkg::CMD_WRSR)
                            begin
                                q_next.st = flash_sr_pkg::ST_WRSR;
                                q_next.bytecnt = 5'h00;
                            end
                            else
                                q_next.st = flash_sr_pkg::ST_IGNORE;
                        end
                        flash_sr_pkg::ST_WRSR:
                        begin
                            // only the first data byte counts; more kills it
                            if (!q_reg.wr_full && q_reg.bytecnt == 5'h00)
                                q_next.wr_data = sh;
                            q_next.wr_full = (q_reg.bytecnt == 5'h00);
                        end
                        flash_sr_pkg::ST_IGNORE:
                            q_next.bytecnt = 5'h02;
                        default:
                        begin
                            // hold at the top so the id stream stays on zeros
                            if (q_reg.bytecnt == 5'h1f)
                                q_next.bytecnt = q_reg.bytecnt;
                        end
                    endcase
                end
                else if (q_reg.st == flash_sr_pkg::ST_WRSR)
                    q_next.wr_full = 1'b0;
            end
            // output bits on falling edges
            if (clk_fall && (q_reg.st == flash_sr_pkg::ST_RDID
                             || q_reg.st == flash_sr_pkg::ST_RDSR))
            begin
                q_next.douten = 1'b1;
                q_next.dout = q_reg.txbyte[7];
                q_next.txbyte = {q_reg.txbyte[6:0], 1'b0};
                if (q_reg.bitcnt == 3'h0 && q_reg.douten)
                begin
                    // next byte loads after every eighth bit
                    if (q_reg.st == flash_sr_pkg::ST_RDSR)
                        nb = stat_byte(q_reg, seq_busy);
                    else
                        nb = id_byte(q_reg.bytecnt);
                    q_next.dout = nb[7];
                    q_next.txbyte = {nb[6:0], 1'b0};
                end
            end
        end
        if (!rst_n)
        begin
            q_next = '0;
            q_next.s_sel = 2'h3;
            q_next.s_wp = 2'h3;
            q_next.psize = flash_sr_pkg::PSIZE_RESET;
            q_next.lock = flash_sr_pkg::LOCK_RESET;
        end
    end

    // single register stage for the whole record
    always_ff @(posedge clk_sys)
    begin
        q_reg <= q_next;
    end

    // outputs straight from flops
    assign serial_out = q_reg.dout;
    assign serial_out_en = q_reg.douten;
    assign protect_size = q_reg.psize;
    assign write_latch_flag = q_reg.wlatch;
    assign hardware_lock_mode = q_reg.hlock;
    assign bulk_erase_ok = q_reg.bulk_ok;

    ////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_wr_start;
        !q_reg.wbusy ##1 q_reg.wbusy;
    endsequence

    property p_tw_len;
        @(posedge clk_sys) disable iff (!rst_n)
        s_wr_start |-> q_reg.wbusy [*8];
    endproperty
    a_tw_len: assert property (p_tw_len) else $error("status write cycle too short");

    property p_tw_end;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(q_reg.wbusy) |-> !q_reg.wlatch;
    endproperty
    a_tw_end: assert property (p_tw_end) else $error("latch not cleared at cycle end");

    property p_lock_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        hw_lock |=> $stable(q_reg.psize) && $stable(q_reg.lock);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("protect bits changed in lock");

    property p_start_needs_latch;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(q_reg.wbusy) |-> $past(q_reg.wlatch);
    endproperty
    a_start_needs_latch: assert property (p_start_needs_latch) else $error("write w/o latch");

    property p_bulk;
        @(posedge clk_sys) disable iff (!rst_n)
        q_reg.bulk_ok |-> $past(q_reg.psize == 2'h0);
    endproperty
    a_bulk: assert property (p_bulk) else $error("bulk erase allowed with protection");

    property p_rdid_busy;
        @(posedge clk_sys) disable iff (!rst_n)
        (q_reg.st != flash_sr_pkg::ST_RDID) && any_busy |=> q_reg.st != flash_sr_pkg::ST_RDID;
    endproperty
    a_rdid_busy: assert property (p_rdid_busy) else $error("id read decoded while busy");

    property p_standby;
        @(posedge clk_sys) disable iff (!rst_n)
        !sel_act |=> !q_reg.douten && q_reg.st == flash_sr_pkg::ST_IDLE;
    endproperty
    a_standby: assert property (p_standby) else $error("output active after deselect");

    property p_out_edge;
        @(posedge clk_sys) disable iff (!rst_n)
        !clk_fall && sel_act |=> $stable(q_reg.dout);
    endproperty
    a_out_edge: assert property (p_out_edge) else $error("output changed off falling edge");

    property p_wr_lock;
        @(posedge clk_sys) disable iff (!rst_n)
        hw_lock |=> !$rose(q_reg.wbusy);
    endproperty
    a_wr_lock: assert property (p_wr_lock) else $error("write in lock mode");

    property p_latch_src;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(q_reg.wlatch) |-> $past(q_reg.shreg == flash_sr_pkg::CMD_WREN);
    endproperty
    a_latch_src: assert property (p_latch_src) else $error("latch set without enable");

    property p_wr_exact;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(q_reg.wbusy) |-> $past(q_reg.wr_full && q_reg.bitcnt == 3'h0);
    endproperty
    a_wr_exact: assert property (p_wr_exact) else $error("write on cut data byte");
endmodule // flash_status_id_protect

// ---- verif/spi_master_model.sv ----
// serial bus master model that runs command sessions against the block
module spi_master_model (
    // system
    input wire logic clk_sys,
    // serial bus
    output logic sel_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_en,
    // received bytes and drive watch
    output logic [7:0] rx_byte,
    output logic rx_stb,
    output logic saw_en
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // idle: deselected, clock parked low
    initial
    begin
        sel_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
        saw_en = 1'b0;
    end

    // notes any cycle with select low in which the device drives its output
    always @(posedge clk_sys)
        if (!sel_n && miso_en)
            saw_en <= 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // nin bits of tx go out msb first, then nout bytes are read back;
    // select rises right after the last clock, so a short nin aborts
    task automatic session(input logic [15:0] tx, input int nin, input int nout);
        logic [7:0] sh;
        begin
            sh = 8'h00;
            @(posedge clk_sys);
            sel_n <= 1'b0;
            saw_en <= 1'b0;
            for (int i = 0; i < nin + 8 * nout; i++)
            begin
                // data changes in the low phase; idle bits flip so nothing stale
                mosi <= (i < nin) ? tx[15 - i] : ~mosi;
                repeat (8) @(posedge clk_sys);
                sclk <= 1'b1;
                sh = {sh[6:0], miso};
                if (i >= nin && (i - nin) % 8 == 7)
                begin
                    rx_byte <= sh;
                    rx_stb <= 1'b1;
                end
                @(posedge clk_sys);
                rx_stb <= 1'b0;
                repeat (7) @(posedge clk_sys);
                sclk <= 1'b0;
            end
            repeat (8) @(posedge clk_sys);
            sel_n <= 1'b1;
            mosi <= ~mosi;
            repeat (8) @(posedge clk_sys);
        end
    endtask
endmodule // spi_master_model

// ---- verif/test_flash_status_id_protect.sv ----
// self-checking bench for the status, identity and protection block
module test_flash_status_id_protect;
    timeunit 1ns;
    timeprecision 1ps;

    // short status write cycle keeps the run brief
    localparam int TW = 400;
    logic clk_sys, rst_n, wprot_n, seq_busy, seq_done, all_sectors_locked, tog;
    logic sel_n, sclk, mosi, miso, serial_out, serial_out_en, rx_stb, saw_en;
    logic write_latch_flag, hardware_lock_mode, bulk_erase_ok;
    logic [1:0] protect_size;
    logic [7:0] rx_byte, d;
    logic [7:0] exp_q[$];
    int fails, n_tests, cyc;

    ////////////////////////////////////////////////////////////////////////
    flash_status_id_protect #(.TW_CNT(TW)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .sel_n(sel_n), .sclk(sclk), .serial_in(mosi), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .wprot_n(wprot_n), .seq_busy(seq_busy),
        .seq_done(seq_done), .protect_size(protect_size),
        .write_latch_flag(write_latch_flag), .hardware_lock_mode(hardware_lock_mode),
        .bulk_erase_ok(bulk_erase_ok), .all_sectors_locked(all_sectors_locked));
    spi_master_model m (.clk_sys(clk_sys), .sel_n(sel_n), .sclk(sclk), .mosi(mosi),
        .miso(miso), .miso_en(serial_out_en), .rx_byte(rx_byte), .rx_stb(rx_stb),
        .saw_en(saw_en));

    // released output shows a changing pattern, never a stale bit
    assign miso = serial_out_en ? serial_out : tog;

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // pattern source and hang guard
    always @(posedge clk_sys)
    begin
        tog <= ~tog;
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        begin
            n_tests++;
            if (seen !== want)
            begin
                fails++;
                $display("mismatch at %0t: got %h want %h", $time, seen, want);
            end
        end
    endtask

    // each received byte is matched to the oldest note
    always @(posedge clk_sys)
        if (rx_stb === 1'b1)
            chk(rx_byte, exp_q.size() ? exp_q.pop_front() : 8'hxx);

    task automatic rdsr(input int n, input logic [7:0] want);
        begin
            repeat (n) exp_q.push_back(want);
            m.session({flash_sr_pkg::CMD_RDSR, 8'h00}, 8, n);
        end
    endtask

    task automatic wren;
        m.session({flash_sr_pkg::CMD_WREN, 8'h00}, 8, 0);
    endtask

    task automatic wrsr(input logic [7:0] v, input int nbits);
        m.session({flash_sr_pkg::CMD_WRSR, v}, nbits, 0);
    endtask

    task automatic report_and_stop;
        begin
            if (fails == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, seq_busy, seq_done, all_sectors_locked, tog} = 5'h00;
        wprot_n = 1'b1;
        fails = 0;
        n_tests = 0;
        cyc = 0;
        void'($urandom(32'heb9f9867));
        d = ($urandom() & 8'h7f) | 8'h04;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdsr(2, 8'h00);
        // full identity stream, then one cut short
        for (int i = 0; i < 22; i++)
            exp_q.push_back(i == 0 || i == 20 ? flash_sr_pkg::ID_MAKER :
                i == 1 || i == 21 ? flash_sr_pkg::ID_TYPE : i == 2 ? flash_sr_pkg::ID_CAP :
                i == 3 ? flash_sr_pkg::UNIQUE_LEN : 8'h00);
        m.session({flash_sr_pkg::CMD_RDID, 8'h00}, 8, 20);
        m.session({flash_sr_pkg::CMD_RDID, 8'h00}, 8, 2);
        rdsr(1, 8'h00);
        wrsr(8'h8c, 16);
        rdsr(1, 8'h00);
        wren();
        rdsr(1, 8'h02);
        wrsr(d, 16);
        rdsr(1, {1'b0, 3'h0, d[3:2], 2'h3});
        repeat (TW) @(posedge clk_sys);
        rdsr(1, {4'h0, d[3:2], 2'h0});
        chk(protect_size, d[3:2]);
        chk(bulk_erase_ok, 1'b0);
        // cut one bit short: discarded, latch kept
        wren();
        wrsr(8'h80, 15);
        repeat (TW) @(posedge clk_sys);
        rdsr(1, {4'h0, d[3:2], 2'h2});
        wrsr(8'h80, 16);
        repeat (TW) @(posedge clk_sys);
        rdsr(1, 8'h80);
        chk(bulk_erase_ok, 1'b1);
        all_sectors_locked <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(bulk_erase_ok, 1'b0);
        all_sectors_locked <= 1'b0;
        chk(hardware_lock_mode, 1'b0);
        // pin low after lock bit: lock mode, writes refused
        wprot_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(hardware_lock_mode, 1'b1);
        wren();
        wrsr(8'h0c, 16);
        repeat (TW) @(posedge clk_sys);
        rdsr(1, 8'h82);
        wprot_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(hardware_lock_mode, 1'b0);
        wrsr(8'h00, 16);
        repeat (TW) @(posedge clk_sys);
        rdsr(1, 8'h00);
        wprot_n <= 1'b0;
        wren();
        wrsr(8'h88, 16);
        repeat (TW) @(posedge clk_sys);
        rdsr(1, 8'h88);
        chk(hardware_lock_mode, 1'b1);
        wprot_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        // identity read while busy gives nothing and leaves the cycle alone
        wren();
        wrsr(8'h00, 16);
        m.session({flash_sr_pkg::CMD_RDID, 8'h00}, 16, 0);
        chk(saw_en, 1'b0);
        repeat (TW) @(posedge clk_sys);
        rdsr(1, 8'h00);
        // write disable drops the latch again
        wren();
        m.session({flash_sr_pkg::CMD_WRDI, 8'h00}, 8, 0);
        rdsr(1, 8'h00);
        seq_busy <= 1'b1;
        rdsr(1, 8'h01);
        seq_busy <= 1'b0;
        wren();
        seq_done <= 1'b1;
        @(posedge clk_sys);
        seq_done <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(write_latch_flag, 1'b0);
        chk(exp_q.size(), 8'h00);
        report_and_stop();
    end
endmodule // test_flash_status_id_protect
